// File: hdl/sdrv_drive.sv
// sdrv_drive: step drive control core, fault latching and indicators.
// assumes link wires and fault inputs are asynchronous; power cycle is reset_n.
// assumes the ramp length is nonzero, since the coil level divides by it.
`timescale 1ns/1ps
// Contract
// - controller raises permit 100 ms before direction
// - direction steady 5 us before step edge
// - step high at least 2.5 us
// - step low at least 2.5 us
// - green lit while no protection active
// - over-current raised from current or short input
// - over-current shows one red flash per frame
// - over-voltage shows two red flashes per frame
// - under-voltage shows three red flashes per frame
// - phase error raised on bad motor wiring
// - phase error shows four red flashes per frame
// - over-temperature shows five red flashes per frame
// - only highest priority fault is displayed
// - any protection frees the motor coils
// - faults latch until power cycle reset
// - coil current ramps 100 ms after start
module sdrv_drive import sdrv_pkg::*; #(
  parameter logic [14:0] PRIO       = PRIO_DEFAULT,
  parameter int unsigned RAMP       = RAMP_CYC,
  parameter int unsigned FRAME      = FRAME_CYC,
  parameter int unsigned FLASH_ON   = FLASH_ON_CYC,
  parameter int unsigned FLASH_OFF  = FLASH_OFF_CYC,
  parameter int unsigned LEVEL_BITS = 8
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  sdrv_link_if.drive                 link,
  input  wire logic                  overCurrentIn,
  input  wire logic                  shortCircuitIn,
  input  wire logic                  overVoltageIn,
  input  wire logic                  underVoltageIn,
  input  wire logic                  phaseErrorIn,
  input  wire logic                  overTempIn,
  output logic                       coilEnable,
  output logic [LEVEL_BITS-1:0]      coilLevel,
  output logic                       stepTaken,
  output logic                       stepForward,
  output logic                       greenLed,
  output logic                       redLed,
  output logic [NUM_FAULTS-1:0]      faultFlags
);
  localparam int unsigned RW = $clog2(RAMP + 1);
  localparam int unsigned FW = $clog2(FRAME + 1);
  localparam int unsigned LW = $clog2(FLASH_ON + FLASH_OFF + 1);

  // returns index of fault in priority slot n
  function automatic logic [2:0] prioSlot(input logic [14:0] p, input int n);
    prioSlot = p[3*(4-n) +: 3];
  endfunction : prioSlot

  logic [2:0]            linkSync;
  logic [5:0]            rawFault;
  logic [5:0]            syncFault;
  logic [NUM_FAULTS-1:0] faultNow;
  logic [NUM_FAULTS-1:0] flags_q;
  logic [NUM_FAULTS-1:0] flags_d;
  logic                  anyFault;
  logic [RW-1:0]         ramp_q;
  logic [RW-1:0]         ramp_d;
  logic                  permitPrev_q;
  logic                  stepPrev_q;
  logic                  stepRise;
  logic                  permitRise;
  logic                  ramping;
  logic [FW-1:0]         frame_q;
  logic [FW-1:0]         frame_d;
  logic                  frameEnd;
  logic [LW-1:0]         phase_q;
  logic [LW-1:0]         phase_d;
  logic [2:0]            flashDone_q;
  logic [2:0]            flashDone_d;
  logic                  phaseEnd;
  logic [2:0]            shownFault;
  logic [2:0]            flashTarget;
  logic                  redOn;
  logic                  red_d;
  logic                  coilOn;
  logic [63:0]           levelProd;
  logic [LEVEL_BITS-1:0] level_d;
  logic                  stepAccept;

  sdrv_sync #(.WIDTH(3)) uLinkSync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .asyncIn ({link.stepStrobe, link.rotationSense, link.outputPermit}),
    .syncOut (linkSync)
  );

  assign rawFault = {overCurrentIn, shortCircuitIn, overVoltageIn,
                     underVoltageIn, phaseErrorIn, overTempIn};
  sdrv_sync #(.WIDTH(6)) uFaultSync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .asyncIn (rawFault),
    .syncOut (syncFault)
  );

  // over-current covers both sustained current and coil shorts
  assign faultNow[FLT_OVER_CURRENT]  = syncFault[5] | syncFault[4];
  assign faultNow[FLT_OVER_VOLTAGE]  = syncFault[3];
  assign faultNow[FLT_UNDER_VOLTAGE] = syncFault[2];
  assign faultNow[FLT_PHASE_ERROR]   = syncFault[1];
  assign faultNow[FLT_OVER_TEMP]     = syncFault[0];
  // flags only set; nothing but reset clears them
  for (genvar g = 0; g < NUM_FAULTS; g++) begin : gFlagLatch
    assign flags_d[g] = flags_q[g] | faultNow[g];
  end
  assign anyFault = |flags_q;

  // fixed priority pick, first set slot wins
  // 3'h7 marks nothing latched; no fault index reaches it
  always_comb begin
    shownFault = 3'h7;
    for (int n = 4; n >= 0; n--) begin
      if (flags_q[prioSlot(PRIO, n)]) begin
        shownFault = prioSlot(PRIO, n);
      end
    end
  end
  // flash count is fault index plus one
  assign flashTarget = (shownFault == 3'h7) ? FLASH_NONE :
                       3'(shownFault + 3'h1);

  assign stepRise   = linkSync[2] & ~stepPrev_q;
  assign permitRise = linkSync[0] & ~permitPrev_q;
  // a fresh permit restarts the soft start
  assign ramp_d  = (permitRise || !linkSync[0]) ? '0 :
                   (ramp_q == RW'(RAMP)) ? ramp_q : RW'(ramp_q + 1'b1);
  assign ramping = ramp_q != RW'(RAMP);

  assign frameEnd = frame_q == FW'(FRAME - 1);
  assign frame_d  = frameEnd ? '0 : FW'(frame_q + 1'b1);
  assign phaseEnd = phase_q == LW'(FLASH_ON + FLASH_OFF - 1);
  assign phase_d  = (frameEnd || phaseEnd) ? '0 : LW'(phase_q + 1'b1);
  assign flashDone_d = frameEnd ? 3'h0 :
                       (phaseEnd && flashDone_q < flashTarget) ? 3'(flashDone_q + 3'h1) :
                       flashDone_q;
  assign redOn = (flashDone_q < flashTarget) && (phase_q < LW'(FLASH_ON));
  assign red_d = anyFault && redOn;

  // coils run only on permit with no fault latched
  assign coilOn     = linkSync[0] && !anyFault;
  // level grows with the ramp; 64 bits so a long ramp cannot overflow
  assign levelProd  = 64'(ramp_d) * 64'((1 << LEVEL_BITS) - 1);
  assign level_d    = anyFault ? '0 : LEVEL_BITS'(levelProd / 64'(RAMP));
  // steps in the ramp are dropped, as a controller must expect
  assign stepAccept = stepRise && coilOn && !ramping;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flags_q      <= FAULT_RESET;
      ramp_q       <= '0;
      permitPrev_q <= 1'b0;
      stepPrev_q   <= 1'b0;
    end else begin
      flags_q      <= flags_d;
      ramp_q       <= ramp_d;
      permitPrev_q <= linkSync[0];
      stepPrev_q   <= linkSync[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      frame_q     <= '0;
      phase_q     <= '0;
      flashDone_q <= 3'h0;
    end else begin
      frame_q     <= frame_d;
      phase_q     <= phase_d;
      flashDone_q <= flashDone_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      coilEnable  <= 1'b0;
      coilLevel   <= '0;
      stepTaken   <= 1'b0;
      stepForward <= 1'b0;
    end else begin
      coilEnable  <= coilOn;
      coilLevel   <= level_d;
      stepTaken   <= stepAccept;
      stepForward <= linkSync[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      greenLed   <= 1'b0;
      redLed     <= 1'b0;
      faultFlags <= '0;
    end else begin
      greenLed   <= !anyFault;
      redLed     <= red_d;
      faultFlags <= flags_q;
    end
  end
endmodule : sdrv_drive

// File: hdl/sdrv_pkg.sv
// sdrv_pkg: shared constants for the step drive and its motion controller.
// assumes a single 25 MHz clock shared by both ends.
package sdrv_pkg;
  localparam int unsigned CLK_HZ        = 25_000_000;
  // times in their own units, cycle counts derived
  localparam int unsigned PERMIT_LEAD_MS = 100;
  localparam int unsigned DIR_SETUP_NS   = 5000;
  localparam int unsigned PULSE_HIGH_NS  = 2500;
  localparam int unsigned PULSE_LOW_NS   = 2500;
  localparam int unsigned RAMP_MS        = 100;
  localparam int unsigned FRAME_MS       = 3000;
  localparam int unsigned FLASH_ON_MS    = 200;
  localparam int unsigned FLASH_OFF_MS   = 200;
  localparam int unsigned PERMIT_LEAD_CYC = PERMIT_LEAD_MS * (CLK_HZ / 1000);
  localparam int unsigned DIR_SETUP_CYC  = (DIR_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PULSE_HIGH_CYC = (PULSE_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PULSE_LOW_CYC  = (PULSE_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RAMP_CYC       = RAMP_MS * (CLK_HZ / 1000);
  localparam int unsigned FRAME_CYC      = FRAME_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_ON_CYC   = FLASH_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_OFF_CYC  = FLASH_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned SYNC_STAGES    = 3;
  localparam int unsigned NUM_FAULTS     = 5;
  // fault bit positions
  localparam int unsigned FLT_OVER_CURRENT = 0;
  localparam int unsigned FLT_OVER_VOLTAGE = 1;
  localparam int unsigned FLT_UNDER_VOLTAGE = 2;
  localparam int unsigned FLT_PHASE_ERROR  = 3;
  localparam int unsigned FLT_OVER_TEMP    = 4;
  localparam logic [2:0]  FLASH_NONE     = 3'h0;
  localparam logic [4:0]  FAULT_RESET    = 5'h00;
  // default display priority, highest first, by fault index
  localparam logic [14:0] PRIO_DEFAULT   = {3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
endpackage : sdrv_pkg

// File: hdl/sdrv_link_if.sv
// sdrv_link_if: control wires from motion controller to step drive.
// assumes both ends share ref_clk; plain levels, no tristate.
`timescale 1ns/1ps
interface sdrv_link_if;
  logic stepStrobe;
  logic rotationSense;
  logic outputPermit;
  modport drive (input stepStrobe, input rotationSense, input outputPermit);
  modport ctrl  (output stepStrobe, output rotationSense, output outputPermit);
endinterface : sdrv_link_if

// File: hdl/sdrv_sync.sv
// sdrv_sync: three-stage synchroniser with agreement filter.
// assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/1ps
module sdrv_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_d;
  // stage one is read only by stage two
  assign out_d = ((s2_q ~^ s3_q) & s2_q) | (~(s2_q ~^ s3_q) & syncOut);
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      syncOut <= '0;
    end else begin
      s1_q    <= asyncIn;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      syncOut <= out_d;
    end
  end
endmodule : sdrv_sync

// File: hdl/sdrv_ctrl.sv
// sdrv_ctrl: motion controller end producing step, direction and permit.
// assumes user requests arrive on ref_clk; one move request at a time.
`timescale 1ns/1ps
module sdrv_ctrl import sdrv_pkg::*; #(
  parameter int unsigned LEAD  = PERMIT_LEAD_CYC,
  parameter int unsigned SETUP = DIR_SETUP_CYC,
  parameter int unsigned HIGH  = PULSE_HIGH_CYC,
  parameter int unsigned LOW   = PULSE_LOW_CYC
) (
  input  wire logic  ref_clk,
  input  wire logic  reset_n,
  sdrv_link_if.ctrl  link,
  input  wire logic  permitReq,
  input  wire logic  stepValid,
  input  wire logic  stepDir,
  output logic       stepReady,
  output logic       permitReady
);
  localparam int unsigned CW = $clog2(LEAD + SETUP + HIGH + LOW + 1);
  typedef enum logic [2:0] {IDLE, SETUP_WAIT, PULSE_HI, PULSE_LO} sdrv_cstate_t;
  sdrv_cstate_t  state_q;
  sdrv_cstate_t  state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] lead_q;
  logic          permit_q;
  logic          dir_q;
  logic          dir_d;
  logic          leadDone;

  assign leadDone    = lead_q == CW'(LEAD);
  assign permitReady = permit_q && leadDone;
  assign stepReady   = permitReady && state_q == IDLE;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 1'b1;
    dir_d   = dir_q;
    case (state_q)
      IDLE: begin
        cnt_d = '0;
        if (stepValid && permitReady) begin
          dir_d   = stepDir;
          state_d = SETUP_WAIT;
        end
      end
      SETUP_WAIT: if (cnt_q == CW'(SETUP - 1)) begin
        cnt_d   = '0;
        state_d = PULSE_HI;
      end
      PULSE_HI: if (cnt_q == CW'(HIGH - 1)) begin
        cnt_d   = '0;
        state_d = PULSE_LO;
      end
      PULSE_LO: if (cnt_q == CW'(LOW - 1)) begin
        cnt_d   = '0;
        state_d = IDLE;
      end
      default: begin
        cnt_d   = '0;
        state_d = IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q  <= IDLE;
      cnt_q    <= '0;
      lead_q   <= '0;
      permit_q <= 1'b0;
      dir_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      permit_q <= permitReq;
      // direction only changes after permit has led by the full time
      lead_q   <= !permitReq ? '0 : (leadDone ? lead_q : CW'(lead_q + 1'b1));
      dir_q    <= dir_d;
    end
  end

  assign link.outputPermit  = permit_q;
  assign link.rotationSense = dir_q;
  assign link.stepStrobe    = state_q == PULSE_HI;
endmodule : sdrv_ctrl

// File: dv/sdrv_link_checker.sv
// sdrv_link_checker: timing checks on the controller-to-drive wires.
// assumes one ref_clk domain; all figures in ref_clk cycles.
`timescale 1ns/1ps
module sdrv_link_checker import sdrv_pkg::*; #(
  parameter int unsigned LEAD  = PERMIT_LEAD_CYC,
  parameter int unsigned SETUP = DIR_SETUP_CYC,
  parameter int unsigned HIGH  = PULSE_HIGH_CYC,
  parameter int unsigned LOW   = PULSE_LOW_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic stepStrobe,
  input wire logic rotationSense,
  input wire logic outputPermit
);
  // saturating counters, so long idle spans never wrap into a false short figure
  logic [15:0] hiCnt_q, loCnt_q, dirCnt_q, permCnt_q, perCnt_q;
  logic        dirLast_q, strobeLast_q;
  function automatic logic [15:0] sat(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h1;
  endfunction : sat
  always_ff @(posedge ref_clk) begin
    dirLast_q <= rotationSense;
    strobeLast_q <= stepStrobe;
    if (!reset_n) begin
      hiCnt_q <= 16'h0;
      loCnt_q <= 16'hFFFF;
      permCnt_q <= 16'h0;
      dirCnt_q <= 16'hFFFF;
      perCnt_q <= 16'hFFFF;
    end else begin
      hiCnt_q <= stepStrobe ? sat(hiCnt_q) : 16'h0;
      loCnt_q <= stepStrobe ? 16'h0 : sat(loCnt_q);
      permCnt_q <= outputPermit ? sat(permCnt_q) : 16'h0;
      dirCnt_q <= (rotationSense != dirLast_q) ? 16'h1 : sat(dirCnt_q);
      perCnt_q <= (stepStrobe && !strobeLast_q) ? 16'h1 : sat(perCnt_q);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  high_width_a: assert property ($fell(stepStrobe) |-> hiCnt_q >= HIGH)
    else $error("step pulse high phase too short");
  low_width_a: assert property ($rose(stepStrobe) |-> loCnt_q >= LOW)
    else $error("step low phase too short");
  step_period_a: assert property ($rose(stepStrobe) |-> perCnt_q >= HIGH + LOW)
    else $error("step pulses too close");
  dir_setup_a: assert property ($rose(stepStrobe) |-> dirCnt_q >= SETUP)
    else $error("direction not settled before step");
  dir_steady_a: assert property (stepStrobe |-> $stable(rotationSense))
    else $error("direction moved during step pulse");
  permit_lead_a: assert property ($changed(rotationSense) |-> permCnt_q >= LEAD)
    else $error("direction set too soon after permit");
  step_permit_a: assert property ($rose(stepStrobe) |-> outputPermit && permCnt_q >= LEAD)
    else $error("step without settled permit");
  reset_quiet_a: assert property (disable iff (1'b0) !reset_n |=> !stepStrobe && !outputPermit)
    else $error("link active during reset");
endmodule : sdrv_link_checker

// File: dv/testbench.sv
// testbench: controller and drive joined by the link; checks steps and fault display.
// assumes shortened ramp, frame and flash counts; reset doubles as power cycle.
`timescale 1ns/1ps
module testbench import sdrv_pkg::*;;
  localparam int unsigned FRM = 200;
  logic       ref_clk, reset_n, permitReq, stepValid, stepDir;
  logic       stepReady, permitReady, coilEnable, stepTaken, stepForward, greenLed, redLed;
  logic [7:0] coilLevel;
  logic [4:0] faultFlags;
  logic [5:0] faultIn;
  int         num_errors, samples_checked;
  sdrv_link_if link ();
  sdrv_ctrl #(.LEAD(20)) i_sdrv_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .link(link.ctrl),
    .permitReq(permitReq), .stepValid(stepValid), .stepDir(stepDir), .stepReady(stepReady),
    .permitReady(permitReady));
  sdrv_drive #(.RAMP(50), .FRAME(FRM), .FLASH_ON(5), .FLASH_OFF(5)) i_sdrv_drive (
    .ref_clk(ref_clk), .reset_n(reset_n), .link(link.drive), .overCurrentIn(faultIn[0]),
    .overVoltageIn(faultIn[1]), .underVoltageIn(faultIn[2]), .phaseErrorIn(faultIn[3]),
    .overTempIn(faultIn[4]), .shortCircuitIn(faultIn[5]), .coilEnable(coilEnable),
    .coilLevel(coilLevel), .stepTaken(stepTaken), .stepForward(stepForward),
    .greenLed(greenLed), .redLed(redLed), .faultFlags(faultFlags));
  sdrv_link_checker #(.LEAD(20)) i_sdrv_link_checker (.ref_clk(ref_clk), .reset_n(reset_n),
    .stepStrobe(link.stepStrobe), .rotationSense(link.rotationSense),
    .outputPermit(link.outputPermit));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic do_reset(input logic [5:0] flt);
    reset_n = 1'b0;
    faultIn = 6'h00;
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(greenLed, 8'h01);
    chk(faultFlags, 8'h00);
    faultIn = flt;
    repeat (10) @(negedge ref_clk);
    faultIn = 6'h00;
    repeat (10) @(negedge ref_clk);
  endtask : do_reset
  // any frame-long window of a periodic display holds exactly one group
  task automatic count_red(output int rises);
    logic last;
    repeat (FRM) @(negedge ref_clk);
    last = redLed;
    rises = 0;
    repeat (FRM) begin
      @(negedge ref_clk);
      if (redLed && !last) rises++;
      last = redLed;
    end
  endtask : count_red
  task automatic do_step(input logic dir);
    int n;
    stepValid = 1'b1;
    stepDir = dir;
    while (stepReady !== 1'b1 && n < 400) begin
      n++;
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    stepValid = 1'b0;
    while (stepTaken !== 1'b1 && n < 800) begin
      n++;
      @(negedge ref_clk);
    end
    chk(stepTaken, 8'h01);
    chk(stepForward, {7'h0, dir});
  endtask : do_step
  task automatic t_step();
    int r;
    do_reset(6'h00);
    permitReq = 1'b1;
    for (int n = 0; n < 100 && permitReady !== 1'b1; n++) @(negedge ref_clk);
    repeat (60) @(negedge ref_clk);
    chk(coilEnable, 8'h01);
    chk(coilLevel != 8'h00, 8'h01);
    do_step(1'b1);
    do_step(1'b0);
    do_step(1'b0);
    count_red(r);
    chk(r[7:0], 8'h00);
  endtask : t_step
  task automatic t_fault();
    int r;
    for (int k = 0; k < 6; k++) begin
      do_reset(6'h01 << k);
      chk({3'h0, faultFlags}, 8'h01 << (k % 5));
      chk(greenLed, 8'h00);
      chk({coilEnable, coilLevel[6:0]} | {7'h0, coilLevel[7]}, 8'h00);
      count_red(r);
      chk(r[7:0], 8'(k % 5 + 1));
    end
  endtask : t_fault
  task automatic t_prio();
    int r;
    do_reset(6'h1E);
    count_red(r);
    chk(r[7:0], 8'h02);
    do_reset(6'h18);
    count_red(r);
    chk(r[7:0], 8'h04);
  endtask : t_prio
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    reset_n = 1'b0;
    permitReq = 1'b0;
    stepValid = 1'b0;
    stepDir = 1'b0;
    faultIn = 6'h00;
    @(negedge ref_clk);
    t_step();
    t_fault();
    t_prio();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    close_out();
  end
endmodule : testbench
